/* File: hdl/aof_pkg.sv */
package aof_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths and timing
   localparam int          SAMPLE_W       = 12;
   localparam int          LANES_DDR      = 6;
   localparam int          VALUE_W        = 14;
   localparam int          CORE_CLK_NS    = 50;
   localparam int          FCLK_PERIOD_NS = 400;
   localparam int          SAMPLE_CYC     = FCLK_PERIOD_NS / CORE_CLK_NS;
   localparam logic [2:0]  CNT_LAST       = 3'(SAMPLE_CYC - 1);
   localparam logic [2:0]  CNT_TAKE       = 3'(SAMPLE_CYC - 2);
   localparam logic [2:0]  CNT_HALF       = 3'(SAMPLE_CYC / 2);
   localparam logic [2:0]  CNT_ZERO       = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // clock control register fields
   localparam int          CC_W           = 4;
   localparam int          CC_DCS_BIT     = 0;
   localparam int          CC_INV_BIT     = 1;
   localparam int          CC_PHASE_LSB   = 2;
   localparam logic [3:0]  CC_RESET       = 4'h0;

   // output mode register fields
   localparam int          OM_W           = 7;
   localparam int          OM_MODE_LSB    = 0;
   localparam int          OM_TERM_BIT    = 2;
   localparam int          OM_DIS_BIT     = 3;
   localparam int          OM_CUR_LSB     = 4;
   localparam logic [6:0]  OM_RESET       = 7'h00;

   // format register fields
   localparam int          FMT_W          = 6;
   localparam int          FMT_TWOS_BIT   = 0;
   localparam int          FMT_RAND_BIT   = 1;
   localparam int          FMT_ABP_BIT    = 2;
   localparam int          FMT_TEST_BIT   = 3;
   localparam int          FMT_PAT_LSB    = 4;
   localparam logic [5:0]  FMT_RESET      = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // output modes and test patterns
   localparam logic [1:0]  MODE_FULL_CMOS = 2'h0;
   localparam logic [1:0]  MODE_DDR_CMOS  = 2'h1;
   localparam logic [1:0]  MODE_DDR_LVDS  = 2'h2;
   localparam logic [1:0]  PAT_ONES       = 2'h0;
   localparam logic [1:0]  PAT_ZEROS      = 2'h1;
   localparam logic [1:0]  PAT_ALT        = 2'h2;
   localparam logic [1:0]  PAT_CHECK      = 2'h3;
   localparam logic [12:0] CHECK_A        = 13'h1555;
   localparam logic [12:0] CHECK_B        = 13'h0AAA;
   localparam logic [12:0] ALL_ONES       = 13'h1FFF;
   localparam logic [12:0] ALL_ZEROS      = 13'h0000;

   // coding
   localparam logic signed [13:0] FS_POS  = 14'sh07FF;
   localparam logic signed [13:0] FS_NEG  = 14'sh3800;
   localparam logic [11:0] MID_CODE       = 12'h800;
   localparam logic [11:0] CODE_MAX       = 12'hFFF;
   localparam logic [11:0] CODE_MIN       = 12'h000;
   localparam logic [11:0] ODD_MASK       = 12'hAAA;

   ////////////////////////////////////////////////////////////////////////////
   // lvds drive current in microamps
   localparam logic [15:0] UA_DEFAULT     = 16'h0DAC;
   localparam logic [15:0] TERM_NUM       = 16'h0008;
   localparam logic [15:0] TERM_DEN       = 16'h0005;

   function automatic logic [15:0] lvds_base_ua(input logic [2:0] code);
      case (code)
         3'h1:    lvds_base_ua = 16'h0FA0;
         3'h2:    lvds_base_ua = 16'h1194;
         3'h3:    lvds_base_ua = 16'h0BB8;
         3'h4:    lvds_base_ua = 16'h09C4;
         3'h5:    lvds_base_ua = 16'h0834;
         3'h6:    lvds_base_ua = 16'h06D6;
         default: lvds_base_ua = UA_DEFAULT;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // capture end registers
   localparam logic [3:0]  RX_CTRL        = 4'h0;
   localparam logic [3:0]  RX_SAMPLE      = 4'h4;
   localparam logic [3:0]  RX_COUNT       = 4'h8;
   localparam int          RXC_MODE_LSB   = 0;
   localparam int          RXC_RAND_BIT   = 2;
   localparam int          RXC_ABP_BIT    = 3;
   localparam int          RXC_INV_BIT    = 4;
   localparam int          RXC_W          = 5;
   localparam logic [4:0]  RXC_RESET      = 5'h00;
   localparam int          RXS_OVF_BIT    = 12;
   localparam int          RXS_VALID_BIT  = 16;

endpackage

/* File: hdl/aof_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface aof_link_if;
   // driven by the converter end, enables low while driving
   logic        fclk_pos_o;
   logic        fclk_neg_o;
   logic [11:0] sample_bits_o;
   logic        overflow_flag_o;
   logic        out_oen;
   // resolved pin levels; the receiving pins are pulled low while the
   // outputs are disabled, so the receiver never reads a stale level
   wire         forwarded_clock_pos;
   wire         forwarded_clock_neg;
   wire  [11:0] sample_bits;
   wire         overflow_flag;

   assign forwarded_clock_pos = out_oen ? 1'b0 : fclk_pos_o;
   assign forwarded_clock_neg = out_oen ? 1'b0 : fclk_neg_o;
   assign sample_bits         = out_oen ? 12'h000 : sample_bits_o;
   assign overflow_flag       = out_oen ? 1'b0 : overflow_flag_o;

   modport adc (
      output fclk_pos_o,
      output fclk_neg_o,
      output sample_bits_o,
      output overflow_flag_o,
      output out_oen
   );
   modport rcv (
      input  forwarded_clock_pos,
      input  forwarded_clock_neg,
      input  sample_bits,
      input  overflow_flag
   );
endinterface
`default_nettype wire

/* File: hdl/aof_formatter.sv */
`timescale 1ns/10ps
`default_nettype none
module aof_formatter (
   // conversion result
   input  wire logic signed [13:0] sample_value,
   // options
   input  wire logic [5:0]         format_register,
   input  wire logic               alt_phase,
   // formatted word
   output logic [11:0]             word,
   output logic                    overflow
);
   logic       over;
   logic       under;
   logic       abp;
   logic [1:0] pat;

   always_comb begin
      over     = sample_value > aof_pkg::FS_POS;
      under    = sample_value <= aof_pkg::FS_NEG;
      overflow = over | under;
      abp      = format_register[aof_pkg::FMT_ABP_BIT];
      pat      = format_register[aof_pkg::FMT_PAT_LSB +: 2];
      // coding comes first, saturating out of range inputs
      if (over) begin
         word = aof_pkg::CODE_MAX;
      end else if (under) begin
         word = aof_pkg::CODE_MIN;
      end else begin
         word = sample_value[11:0] ^ aof_pkg::MID_CODE;
      end
      // abp forces offset binary
      if (format_register[aof_pkg::FMT_TWOS_BIT] && !abp) begin
         word = word ^ aof_pkg::MID_CODE;
      end
      if (format_register[aof_pkg::FMT_RAND_BIT]) begin
         word[11:1] = word[11:1] ^ {11{word[0]}};
      end
      if (abp) begin
         word = word ^ aof_pkg::ODD_MASK;
      end
      // test patterns override everything above
      if (format_register[aof_pkg::FMT_TEST_BIT]) begin
         case (pat)
            aof_pkg::PAT_ONES:  {overflow, word} = aof_pkg::ALL_ONES;
            aof_pkg::PAT_ZEROS: {overflow, word} = aof_pkg::ALL_ZEROS;
            aof_pkg::PAT_ALT: begin
               {overflow, word} = alt_phase ? aof_pkg::ALL_ZEROS : aof_pkg::ALL_ONES;
            end
            default: begin
               {overflow, word} = alt_phase ? aof_pkg::CHECK_B : aof_pkg::CHECK_A;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: hdl/aof_adc_end.sv */
// Notes on behaviour
// - internal termination raises drive current 1.6x
// - overflow high above or at/below limits
// - overflow has same latency as data
// - full rate: data changes on clock fall
// - ddr modes: data changes on both edges
// - clock delayed 0, 45, 90, 135 degrees
// - phase shift needs duty stabilizer enabled
// - invert bit flips both forwarded clocks
// - offset binary default, twos when selected
// - 12-bit codes, saturate at range ends
// - randomizer xors upper bits with bit 0
// - receiver xors upper bits with bit 0
// - alternate polarity inverts odd data bits
// - receiver re-inverts odd bits
// - randomizer and alternate polarity independent
// - alternate polarity forces offset binary
// - four test patterns on all outputs
// - test pattern bypasses all other formatting
// - output disable floats every output
// - disable only for long idle periods
// - ddr puts two bits on six lines
// - stabilizer by register or chip select
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module aof_adc_end (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               nrst,
   // conversion results
   input  wire logic signed [13:0] sample_value,
   output logic                    sample_take,
   // mode registers
   input  wire logic [3:0]         clock_control_register,
   input  wire logic [6:0]         output_mode_register,
   input  wire logic [5:0]         format_register,
   // parallel programming pins
   input  wire logic               par_mode_pin,
   input  wire logic               cs_pin,
   input  wire logic               sck_pin,
   // analog side controls
   output logic                    dcs_enable,
   output logic                    term_enable,
   output logic [15:0]             lvds_drive_ua,
   // link
   aof_link_if.adc                 link
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {sck_pin, cs_pin, par_mode_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // formatting

   logic [11:0] fmt_word;
   logic        fmt_ovf;
   logic        alt_q;
   logic        alt_d;

   aof_formatter u_fmt (
      .sample_value    (sample_value),
      .format_register (format_register),
      .alt_phase       (alt_q),
      .word            (fmt_word),
      .overflow        (fmt_ovf)
   );

   // picks one bit of each pair for the six ddr lanes
   function automatic logic [11:0] ddr_half(input logic [11:0] w, input logic odd);
      logic [11:0] r;
      r = 12'h000;
      for (int k = 0; k < aof_pkg::LANES_DDR; k++) begin
         r[k] = w[2*k + int'(odd)];
      end
      ddr_half = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // sample timing and output word

   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   logic [11:0] word_q;
   logic [11:0] word_d;
   logic        wovf_q;
   logic        wovf_d;
   logic [11:0] bits_q;
   logic [11:0] bits_d;
   logic        ovf_q;
   logic        ovf_d;
   logic        fclk_q;
   logic        fclk_d;
   logic        oen_q;
   logic        oen_d;
   logic [1:0]  mode;
   logic        ddr;
   logic [2:0]  shift;
   logic [2:0]  phase;
   logic        inv;

   always_comb begin
      if (pin_s2_q[0]) begin
         mode = pin_s2_q[2] ? aof_pkg::MODE_DDR_LVDS : aof_pkg::MODE_FULL_CMOS;
      end else begin
         mode = output_mode_register[aof_pkg::OM_MODE_LSB +: 2];
      end
      ddr = (mode == aof_pkg::MODE_DDR_CMOS) || (mode == aof_pkg::MODE_DDR_LVDS);
      cnt_d = (cnt_q == aof_pkg::CNT_LAST) ? aof_pkg::CNT_ZERO : cnt_q + 3'h1;
      sample_take = (cnt_q == aof_pkg::CNT_TAKE);
      word_d = word_q;
      wovf_d = wovf_q;
      alt_d  = alt_q;
      // overflow stays paired with the word it came with
      if (sample_take) begin
         word_d = fmt_word;
         wovf_d = fmt_ovf;
         alt_d  = ~alt_q;
      end
      bits_d = bits_q;
      ovf_d  = ovf_q;
      if (cnt_d == aof_pkg::CNT_ZERO) begin
         ovf_d  = wovf_q;
         bits_d = ddr ? ddr_half(word_q, 1'b0) : word_q;
      end else if (ddr && (cnt_d == aof_pkg::CNT_HALF)) begin
         bits_d = ddr_half(word_q, 1'b1);
      end
      // without the stabilizer the shifted clock is not usable, so no shift
      shift = dcs_enable ? {1'b0, clock_control_register[aof_pkg::CC_PHASE_LSB +: 2]}
                         : 3'h0;
      inv   = clock_control_register[aof_pkg::CC_INV_BIT];
      // one core cycle is 45 degrees of the forwarded clock
      phase = cnt_d - shift - (inv ? aof_pkg::CNT_HALF : 3'h0);
      fclk_d = phase[2];
      oen_d = output_mode_register[aof_pkg::OM_DIS_BIT];
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 3'h0;
         word_q <= 12'h000;
         wovf_q <= 1'b0;
         alt_q  <= 1'b0;
         bits_q <= 12'h000;
         ovf_q  <= 1'b0;
         fclk_q <= 1'b0;
         oen_q  <= 1'b1;
      end else begin
         cnt_q  <= cnt_d;
         word_q <= word_d;
         wovf_q <= wovf_d;
         alt_q  <= alt_d;
         bits_q <= bits_d;
         ovf_q  <= ovf_d;
         fclk_q <= fclk_d;
         oen_q  <= oen_d;
      end
   end

   assign link.fclk_pos_o      = fclk_q;
   assign link.fclk_neg_o      = ~fclk_q;
   assign link.sample_bits_o   = bits_q;
   assign link.overflow_flag_o = ovf_q;
   assign link.out_oen         = oen_q;

   ////////////////////////////////////////////////////////////////////////////
   // analog side controls

   logic        dcs_q;
   logic        dcs_d;
   logic        term_q;
   logic        term_d;
   logic [15:0] ua_q;
   logic [15:0] ua_d;
   logic [15:0] base_ua;

   always_comb begin
      // parallel programming takes the stabilizer from chip select
      dcs_d = pin_s2_q[0] ? pin_s2_q[1]
                          : clock_control_register[aof_pkg::CC_DCS_BIT];
      term_d  = output_mode_register[aof_pkg::OM_TERM_BIT] && !pin_s2_q[0];
      base_ua = pin_s2_q[0] ? aof_pkg::UA_DEFAULT
                            : aof_pkg::lvds_base_ua(output_mode_register[aof_pkg::OM_CUR_LSB +: 3]);
      ua_d = term_d ? (base_ua * aof_pkg::TERM_NUM) / aof_pkg::TERM_DEN
                    : base_ua;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dcs_q  <= 1'b0;
         term_q <= 1'b0;
         ua_q   <= aof_pkg::UA_DEFAULT;
      end else begin
         dcs_q  <= dcs_d;
         term_q <= term_d;
         ua_q   <= ua_d;
      end
   end

   assign dcs_enable    = dcs_q;
   assign term_enable   = term_q;
   assign lvds_drive_ua = ua_q;

endmodule
`default_nettype wire

/* File: hdl/aof_capture_end.sv */
`timescale 1ns/10ps
`default_nettype none
module aof_capture_end (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // register port
   input  wire logic [3:0]  bus_addr,
   input  wire logic [31:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic [31:0]      bus_rdata,
   // recovered samples
   output logic [11:0]      sample_word,
   output logic             sample_overflow,
   output logic             sample_strobe,
   // link
   aof_link_if.rcv          link
);

   ////////////////////////////////////////////////////////////////////////////
   // link synchronisers, only stage two and the clock's third stage are read

   logic [13:0] s1_q;
   logic [13:0] s2_q;
   logic        clk3_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q   <= 14'h0000;
         s2_q   <= 14'h0000;
         clk3_q <= 1'b0;
      end else begin
         s1_q   <= {link.forwarded_clock_pos, link.overflow_flag, link.sample_bits};
         s2_q   <= s1_q;
         clk3_q <= s2_q[13];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture and decode

   logic [4:0]  ctrl_q;
   logic [4:0]  ctrl_d;
   logic [5:0]  lo_q;
   logic [5:0]  lo_d;
   logic [11:0] word_q;
   logic [11:0] word_d;
   logic        ovf_q;
   logic        ovf_d;
   logic        stb_q;
   logic        stb_d;
   logic        valid_q;
   logic        valid_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        lvl;
   logic        prev;
   logic        ddr;
   logic [11:0] raw;

   always_comb begin
      lvl  = s2_q[13] ^ ctrl_q[aof_pkg::RXC_INV_BIT];
      prev = clk3_q ^ ctrl_q[aof_pkg::RXC_INV_BIT];
      ddr  = ctrl_q[aof_pkg::RXC_MODE_LSB +: 2] != aof_pkg::MODE_FULL_CMOS;
      lo_d = lo_q;
      raw  = s2_q[11:0];
      if (ddr) begin
         for (int k = 0; k < aof_pkg::LANES_DDR; k++) begin
            raw[2*k]     = lo_q[k];
            raw[2*k + 1] = s2_q[k];
         end
      end
      if (ddr && !lvl && prev) begin
         lo_d = s2_q[5:0];
      end
      // decode in reverse order of the encoder
      if (ctrl_q[aof_pkg::RXC_ABP_BIT]) begin
         raw = raw ^ aof_pkg::ODD_MASK;
      end
      if (ctrl_q[aof_pkg::RXC_RAND_BIT]) begin
         raw[11:1] = raw[11:1] ^ {11{raw[0]}};
      end
      stb_d   = lvl && !prev;
      word_d  = stb_d ? raw : word_q;
      ovf_d   = stb_d ? s2_q[12] : ovf_q;
      count_d = stb_d ? count_q + 16'h0001 : count_q;
      // a new sample in the reading cycle keeps the flag set
      valid_d = stb_d || (valid_q && !(bus_rd && bus_addr == aof_pkg::RX_SAMPLE));
      ctrl_d  = (bus_wr && bus_addr == aof_pkg::RX_CTRL) ? bus_wdata[4:0] : ctrl_q;
      rdata_d = 32'h0000_0000;
      if (bus_rd) begin
         case (bus_addr)
            aof_pkg::RX_CTRL:   rdata_d = {27'h0, ctrl_q};
            aof_pkg::RX_SAMPLE: rdata_d = {15'h0, valid_q, 3'h0, ovf_q, word_q};
            aof_pkg::RX_COUNT:  rdata_d = {16'h0, count_q};
            default:            rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q  <= aof_pkg::RXC_RESET;
         lo_q    <= 6'h00;
         word_q  <= 12'h000;
         ovf_q   <= 1'b0;
         stb_q   <= 1'b0;
         valid_q <= 1'b0;
         count_q <= 16'h0000;
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q  <= ctrl_d;
         lo_q    <= lo_d;
         word_q  <= word_d;
         ovf_q   <= ovf_d;
         stb_q   <= stb_d;
         valid_q <= valid_d;
         count_q <= count_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus_rdata       = rdata_q;
   assign sample_word     = word_q;
   assign sample_overflow = ovf_q;
   assign sample_strobe   = stb_q;

endmodule
`default_nettype wire

/* File: tb/aof_link_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module aof_link_asserts (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // converter end drive
   input wire logic        fclk_pos_o,
   input wire logic        fclk_neg_o,
   input wire logic [11:0] sample_bits_o,
   input wire logic        overflow_flag_o,
   input wire logic        out_oen
);
   ////////////////////////////////////////
   // mirror of the 8-cycle sample counter; age masks the start-up clock
   // pulse, which may be short after a phase change under reset
   logic [2:0] ph_q;
   logic [2:0] ph_d;
   logic [3:0] age_q;
   logic [3:0] age_d;
   always_comb begin
      ph_d  = ph_q + 3'h1;
      age_d = age_q[3] ? age_q : age_q + 4'h1;
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ph_q  <= 3'h0;
         age_q <= 4'h0;
      end else begin
         ph_q  <= ph_d;
         age_q <= age_d;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_clk_pair; !out_oen |-> fclk_neg_o != fclk_pos_o; endproperty
   a_clk_pair: assert property (p_clk_pair) else $error("clock pair");
   property p_clk_high; $rose(fclk_pos_o) && age_q[3] |-> fclk_pos_o[*4] ##1 !fclk_pos_o; endproperty
   a_clk_high: assert property (p_clk_high) else $error("clock high");
   property p_clk_low; $fell(fclk_pos_o) && age_q[3] |-> !fclk_pos_o[*4] ##1 fclk_pos_o; endproperty
   a_clk_low: assert property (p_clk_low) else $error("clock low");
   property p_bits_step; $changed(sample_bits_o) |-> ph_q[1:0] == 2'h0; endproperty
   a_bits_step: assert property (p_bits_step) else $error("data step");
   property p_hi_lanes; $changed(sample_bits_o[11:6]) |-> ph_q == 3'h0; endproperty
   a_hi_lanes: assert property (p_hi_lanes) else $error("upper lanes");
   property p_odd_half; $changed(sample_bits_o) && ph_q == 3'h4 |-> sample_bits_o[11:6] == 6'h00; endproperty
   a_odd_half: assert property (p_odd_half) else $error("odd half");
   property p_ovf_step; $changed(overflow_flag_o) |-> ph_q == 3'h0; endproperty
   a_ovf_step: assert property (p_ovf_step) else $error("overflow step");
   property p_quiet; !age_q[3] |-> sample_bits_o == 12'h000 && !overflow_flag_o; endproperty
   a_quiet: assert property (p_quiet) else $error("early output");
endmodule
`default_nettype wire

/* File: tb/tb_adc_output_formatter.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_adc_output_formatter;
   logic               core_clk;
   logic               nrst;
   logic               par_mode;
   logic               cs_lvl;
   logic signed [13:0] sample_value;
   logic [3:0]         cc;
   logic [6:0]         om;
   logic [5:0]         fmt;
   logic [3:0]         bus_addr;
   logic [31:0]        bus_wdata;
   logic [31:0]        bus_rdata;
   logic [31:0]        d;
   logic               bus_wr;
   logic               bus_rd;
   logic [11:0]        word;
   logic               ovf;
   logic               strobe;
   logic               dcs;
   logic               term;
   logic [15:0]        ua;
   int                 n_errors;
   int                 compares;
   logic [3:0]         ph_cc [5] = '{4'h0, 4'h9, 4'h7, 4'hD, 4'h8};
   int                 ph_e [5] = '{0, 2, 5, 3, 0};
   logic [19:0]        cases [13] = '{
      {6'h00, 14'h0000}, {6'h01, 14'h0000},
      {6'h00, 14'h07FF}, {6'h01, 14'h0800},
      {6'h00, 14'h3800}, {6'h01, 14'h37FF},
      {6'h01, 14'h3FFF}, {6'h02, 14'h0005},
      {6'h04, 14'h3FFB}, {6'h07, 14'h0123},
      {6'h03, 14'h0234}, {6'h0F, 14'h0000},
      {6'h1B, 14'h0000}};
   aof_link_if link ();
   aof_adc_end u_aof_adc_end (.core_clk, .nrst, .sample_value, .sample_take(),
      .clock_control_register(cc), .output_mode_register(om), .format_register(fmt),
      .par_mode_pin(par_mode), .cs_pin(cs_lvl), .sck_pin(1'b0), .dcs_enable(dcs),
      .term_enable(term), .lvds_drive_ua(ua), .link(link));
   aof_capture_end u_aof_capture_end (.core_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr,
      .bus_rd, .bus_rdata, .sample_word(word), .sample_overflow(ovf),
      .sample_strobe(strobe), .link(link));
   aof_link_asserts u_aof_link_asserts (.core_clk, .nrst, .fclk_pos_o(link.fclk_pos_o),
      .fclk_neg_o(link.fclk_neg_o), .sample_bits_o(link.sample_bits_o),
      .overflow_flag_o(link.overflow_flag_o), .out_oen(link.out_oen));
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic report_and_stop;
      if (n_errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= v;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      @(posedge core_clk);
      d = bus_rdata;
   endtask
   // clock settings change only under reset (om is also changed later without it), so the link never
   // shows a half-length clock pulse while the checker is armed
   task automatic cfg(input logic [3:0] c, input logic [6:0] m);
      @(posedge core_clk);
      cc   <= c;
      om   <= m;
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
   endtask
   function automatic logic [12:0] expw(input logic signed [13:0] v, input logic [5:0] f);
      logic        o;
      logic [11:0] c;
      if (f[3]) return {13{~f[4]}};
      o = v > 14'sh07FF || v <= 14'sh3800;
      c = o ? {12{~v[13]}} : 12'(v + 14'sh0800);
      if (f[0] && !f[2]) c = c ^ 12'h800;
      return {o, c};
   endfunction
   task automatic run(input logic signed [13:0] v, input logic [5:0] f);
      logic [12:0] e;
      logic [11:0] w;
      e = expw(v, f);
      w = e[11:0];
      if (f[1] && !f[3]) w[11:1] = w[11:1] ^ {11{w[0]}};
      if (f[2] && !f[3]) w = w ^ 12'hAAA;
      @(posedge core_clk);
      sample_value <= v;
      fmt          <= f;
      wr(4'h0, {27'h0, cc[1], f[2] & ~f[3], f[1] & ~f[3], om[1:0]});
      repeat (40) @(posedge core_clk);
      if (om[1:0] == 2'h0) `CHK("pins", {e[12], w}, {link.overflow_flag, link.sample_bits})
      rd(4'h4);
      `CHK("sample", {1'b1, e}, {d[16], d[12:0]})
   endtask
   task automatic pat(input logic [5:0] f, input logic [12:0] a, input logic [12:0] b);
      logic [12:0] s [2];
      int          n;
      @(posedge core_clk);
      fmt <= f;
      wr(4'h0, 32'h0);
      repeat (40) @(posedge core_clk);
      for (int i = 0; i < 2; i++) begin
         n = 0;
         @(posedge core_clk);
         while (strobe !== 1'b1 && n++ < 20) @(posedge core_clk);
         s[i] = {ovf, word};
      end
      `CHK("pattern step", a ^ b, s[0] ^ s[1])
      `CHK("pattern value", 1'b1, s[0] === a || s[0] === b)
   endtask
   task automatic phase(input logic [3:0] c, input int e);
      logic o;
      logic k;
      int   n;
      cfg(c, 7'h00);
      repeat (24) @(posedge core_clk);
      `CHK("stabilizer", c[0], dcs)
      o = link.overflow_flag;
      n = 0;
      while (link.overflow_flag === o && n++ < 20) begin
         k = link.forwarded_clock_pos;
         @(posedge core_clk);
      end
      n = 0;
      while (!(k === 1'b1 && link.forwarded_clock_pos === 1'b0) && n < 20) begin
         k = link.forwarded_clock_pos;
         @(posedge core_clk);
         n++;
      end
      `CHK("clock phase", e, n)
   endtask
   ////////////////////////////////////////
   initial begin
      n_errors     = 0;
      compares     = 0;
      nrst         = 1'b0;
      sample_value = 14'sh0000;
      cc           = 4'h0;
      om           = 7'h00;
      fmt          = 6'h28;
      bus_addr     = 4'h0;
      bus_wdata    = 32'h0;
      bus_wr       = 1'b0;
      bus_rd       = 1'b0;
      par_mode     = 1'b0;
      cs_lvl       = 1'b0;
      cfg(4'h0, 7'h00);
      repeat (4) @(posedge core_clk);
      `CHK("drive", 16'h0DAC, ua)
      rd(4'hC);
      `CHK("unmapped", 32'h0, d)
      wr(4'h0, 32'h0000_001F);
      rd(4'h0);
      `CHK("control", 32'h0000_001F, d)
      for (int i = 0; i < 5; i++) phase(ph_cc[i], ph_e[i]);
      cfg(4'h0, 7'h00);
      for (int i = 0; i < 13; i++) run(cases[i][13:0], cases[i][19:14]);
      pat(6'h28, 13'h1FFF, 13'h0000);
      pat(6'h3F, 13'h1555, 13'h0AAA);
      cfg(4'h9, 7'h01);
      run(14'sh0321, 6'h06);
      cfg(4'hB, 7'h02);
      run(14'sh3C00, 6'h03);
      cfg(4'h0, 7'h26);
      repeat (4) @(posedge core_clk);
      `CHK("drive", 16'h1C20, ua)
      `CHK("term", 1'b1, term)
      // disable is entered once, at the end of traffic
      om <= 7'h08;
      repeat (4) @(posedge core_clk);
      `CHK("float", 1'b1, link.out_oen)
      `CHK("float", 12'h000, link.sample_bits)
      `CHK("float", 2'h0, {link.forwarded_clock_pos, link.overflow_flag})
      // parallel programming: the stabilizer follows the chip select pin
      par_mode <= 1'b1;
      cs_lvl   <= 1'b1;
      repeat (6) @(posedge core_clk);
      `CHK("stabilizer pin", 1'b1, dcs)
      report_and_stop;
   end
   // about ten times the expected run
   initial begin
      #500000;
      n_errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
